/* design/bsp_defines.svh */
// Constants of the bridge status and port-timing readback block
// Included by bare name from the package and the design module
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH
`define BSP_LINK_ADDR 7'h18
`define BSP_CMD_DEV_RESET 8'hf0
`define BSP_CMD_SET_PTR 8'he1
`define BSP_CMD_WR_CFG 8'hd2
`define BSP_CMD_ADJ_PORT 8'hc3
`define BSP_CMD_OW_RESET 8'hb4
`define BSP_CMD_OW_BIT 8'h87
`define BSP_CMD_OW_WBYTE 8'ha5
`define BSP_CMD_OW_RBYTE 8'h96
`define BSP_CMD_OW_TRIP 8'h78
`define BSP_PTR_CFG 8'hc3
`define BSP_PTR_STATUS 8'hf0
`define BSP_PTR_DATA 8'he1
`define BSP_PTR_PORT 8'hb4
`define BSP_ST_BUSY 0
`define BSP_ST_PPD 1
`define BSP_ST_SHORT 2
`define BSP_ST_LEVEL 3
`define BSP_ST_RST 4
`define BSP_ST_SBR 5
`define BSP_ST_TSB 6
`define BSP_ST_DIR 7
`define BSP_STATUS_RESET 8'h10
`define BSP_HI_PAD 4'h0
`define BSP_ACK_SLOT 4'h8
`define BSP_LAST_BIT 4'h7
`endif

/* design/bsp_pkg.sv */
// Types of the bridge status and port-timing readback block
// Assumes bsp_defines.svh is on the include path
`include "bsp_defines.svh"
package bsp_pkg;
   typedef enum logic [1:0] {PTR_STATUS, PTR_CFG, PTR_DATA, PTR_PORT} bsp_ptr_t;
   typedef enum logic [2:0] {OP_NONE, OP_RESET, OP_BIT, OP_WBYTE, OP_RBYTE, OP_TRIP} bsp_op_t;
   typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_PARAM, PH_READ, PH_SKIP} bsp_phase_t;
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic busy_s1;
      logic busy_s2;
      bsp_phase_t phase;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic ack_en;
      logic last_byte;
      logic [7:0] cmd;
      logic [7:0] param;
      logic cmd_tgl;
      logic rd_tgl;
      logic rd_first;
   } bsp_lnk_t;
   typedef struct packed {
      logic start;
      logic oe;
      logic [7:0] tx;
   } bsp_neg_t;
   typedef struct packed {
      logic cmd_s1, cmd_s2, cmd_prev;
      logic rd_s1, rd_s2, rd_prev;
      logic line_s1, line_s2;
      logic sda_s1, sda_s2, sda_prev;
      logic scl_s1, scl_s2;
      logic start_pend;
      bsp_ptr_t ptr;
      logic [2:0] port_idx;
      bsp_op_t op;
      logic [7:0] status;
      logic [7:0] rd_byte;
      logic ow_start;
      bsp_op_t ow_op;
      logic [7:0] ow_param;
      logic ow_abort;
      logic cfg_wr;
      logic [7:0] cfg_byte;
      logic port_adj;
      logic [7:0] port_param;
   } bsp_ref_t;
endpackage

/* design/bsp_status_port.sv */
// Status byte and port-timing readback behind the serial host link
// Assumes a single-wire engine on ref_clk and a host link clocked by scl_clk
`timescale 1ns/1ns
`default_nettype none
`include "bsp_defines.svh"

module bsp_status_port (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_oe,
   input wire logic line_in,
   input wire logic eng_done,
   input wire logic eng_presence_smp,
   input wire logic eng_short_smp,
   input wire logic eng_bit1_smp,
   input wire logic eng_bit2_smp,
   input wire logic eng_dir_smp,
   input wire logic eng_dir,
   input wire logic [7:0] read_data,
   input wire logic [3:0] dev_cfg_code,
   input wire logic [3:0] reset_low_std_code,
   input wire logic [3:0] reset_low_od_code,
   input wire logic [3:0] presence_std_code,
   input wire logic [3:0] presence_od_code,
   input wire logic [3:0] write_zero_std_code,
   input wire logic [3:0] write_zero_od_code,
   input wire logic [3:0] recovery_code,
   input wire logic [3:0] pullup_code,
   output logic ow_start,
   output var bsp_pkg::bsp_op_t ow_op,
   output logic [7:0] ow_param,
   output logic ow_abort,
   output logic cfg_wr,
   output logic [7:0] cfg_byte,
   output logic port_adj,
   output logic [7:0] port_param,
   output logic [7:0] status_byte
);

   bsp_pkg::bsp_lnk_t l_q;
   bsp_pkg::bsp_lnk_t l_d;
   bsp_pkg::bsp_neg_t n_q;
   bsp_pkg::bsp_neg_t n_d;
   bsp_pkg::bsp_ref_t r_q;
   bsp_pkg::bsp_ref_t r_d;

   function automatic logic cmd_known(input logic [7:0] c);
      case (c)
         `BSP_CMD_DEV_RESET,
         `BSP_CMD_SET_PTR,
         `BSP_CMD_WR_CFG,
         `BSP_CMD_ADJ_PORT,
         `BSP_CMD_OW_RESET,
         `BSP_CMD_OW_BIT,
         `BSP_CMD_OW_WBYTE,
         `BSP_CMD_OW_RBYTE,
         `BSP_CMD_OW_TRIP: begin
            cmd_known = 1'b1;
         end
         default: begin
            cmd_known = 1'b0;
         end
      endcase
   endfunction

   function automatic logic cmd_two(input logic [7:0] c);
      case (c)
         `BSP_CMD_SET_PTR,
         `BSP_CMD_WR_CFG,
         `BSP_CMD_ADJ_PORT,
         `BSP_CMD_OW_BIT,
         `BSP_CMD_OW_WBYTE,
         `BSP_CMD_OW_TRIP: begin
            cmd_two = 1'b1;
         end
         default: begin
            cmd_two = 1'b0;
         end
      endcase
   endfunction

   function automatic logic ptr_known(input logic [7:0] p);
      ptr_known = (p == `BSP_PTR_CFG) || (p == `BSP_PTR_STATUS) ||
                  (p == `BSP_PTR_DATA) || (p == `BSP_PTR_PORT);
   endfunction

   function automatic bsp_pkg::bsp_ptr_t ptr_map(input logic [7:0] p);
      case (p)
         `BSP_PTR_CFG: begin
            ptr_map = bsp_pkg::PTR_CFG;
         end
         `BSP_PTR_DATA: begin
            ptr_map = bsp_pkg::PTR_DATA;
         end
         `BSP_PTR_PORT: begin
            ptr_map = bsp_pkg::PTR_PORT;
         end
         default: begin
            ptr_map = bsp_pkg::PTR_STATUS;
         end
      endcase
   endfunction

   // Link side, rising edge: byte framing and acknowledge decisions
   always_comb begin
      logic [7:0] byte_in;
      byte_in = {l_q.shreg[6:0], sda_in};
      l_d = l_q;
      l_d.rst_s1 = rst;
      l_d.rst_s2 = l_q.rst_s1;
      l_d.busy_s1 = r_q.status[`BSP_ST_BUSY];
      l_d.busy_s2 = l_q.busy_s1;
      if (l_q.rst_s2) begin
         l_d.phase = bsp_pkg::PH_IDLE;
         l_d.bitcnt = 4'h0;
         l_d.shreg = 8'h00;
         l_d.ack_en = 1'b0;
         l_d.last_byte = 1'b0;
         // Toggles restart with the core synchronisers so no phantom command follows reset
         l_d.cmd_tgl = 1'b0;
         l_d.rd_tgl = 1'b0;
         l_d.rd_first = 1'b0;
      end else if (n_q.start) begin
         l_d.phase = bsp_pkg::PH_ADDR;
         l_d.bitcnt = 4'h1;
         l_d.shreg = {7'h00, sda_in};
         l_d.ack_en = 1'b0;
      end else begin
         case (l_q.phase)
            bsp_pkg::PH_ADDR,
            bsp_pkg::PH_CMD,
            bsp_pkg::PH_PARAM: begin
               if (l_q.bitcnt == `BSP_ACK_SLOT) begin
                  l_d.bitcnt = 4'h0;
                  if (!l_q.ack_en) begin
                     l_d.phase = bsp_pkg::PH_SKIP;
                  end else if (l_q.phase == bsp_pkg::PH_ADDR) begin
                     if (l_q.shreg[0]) begin
                        l_d.phase = bsp_pkg::PH_READ;
                        l_d.rd_tgl = ~l_q.rd_tgl;
                        l_d.rd_first = 1'b1;
                     end else begin
                        l_d.phase = bsp_pkg::PH_CMD;
                     end
                  end else if (l_q.last_byte) begin
                     // Command runs only after its final byte is acknowledged
                     l_d.cmd_tgl = ~l_q.cmd_tgl;
                     l_d.phase = bsp_pkg::PH_SKIP;
                  end else begin
                     l_d.phase = bsp_pkg::PH_PARAM;
                  end
               end else begin
                  l_d.shreg = byte_in;
                  l_d.bitcnt = l_q.bitcnt + 4'h1;
                  if (l_q.bitcnt == `BSP_LAST_BIT) begin
                     case (l_q.phase)
                        bsp_pkg::PH_ADDR: begin
                           l_d.ack_en = (byte_in[7:1] == `BSP_LINK_ADDR);
                        end
                        bsp_pkg::PH_CMD: begin
                           l_d.cmd = byte_in;
                           l_d.ack_en = cmd_known(byte_in) &&
                              !(byte_in == `BSP_CMD_WR_CFG && l_q.busy_s2);
                           l_d.last_byte = !cmd_two(byte_in);
                        end
                        default: begin
                           l_d.param = byte_in;
                           l_d.ack_en = (l_q.cmd != `BSP_CMD_SET_PTR || ptr_known(byte_in)) &&
                              !(l_q.cmd == `BSP_CMD_WR_CFG && l_q.busy_s2);
                           l_d.last_byte = 1'b1;
                        end
                     endcase
                  end
               end
            end
            bsp_pkg::PH_READ: begin
               if (l_q.bitcnt == `BSP_ACK_SLOT) begin
                  l_d.bitcnt = 4'h0;
                  if (!sda_in) begin
                     l_d.rd_tgl = ~l_q.rd_tgl;
                     l_d.rd_first = 1'b0;
                  end else begin
                     // Host not-acknowledge ends the read
                     l_d.phase = bsp_pkg::PH_SKIP;
                  end
               end else begin
                  l_d.bitcnt = l_q.bitcnt + 4'h1;
               end
            end
            default: begin
               l_d.bitcnt = l_q.bitcnt;
            end
         endcase
      end
   end

   always_ff @(posedge scl_clk) begin
      l_q <= l_d;
   end

   // Link side, falling edge: drives the data line for acknowledge and read bits.
   // The read byte is taken here; it was settled well inside the high phase.
   always_comb begin
      n_d = n_q;
      n_d.start = r_q.start_pend;
      n_d.oe = 1'b0;
      if (l_q.rst_s2) begin
         n_d.start = 1'b0;
         n_d.tx = 8'h00;
      end else begin
         case (l_q.phase)
            bsp_pkg::PH_ADDR,
            bsp_pkg::PH_CMD,
            bsp_pkg::PH_PARAM: begin
               n_d.oe = (l_q.bitcnt == `BSP_ACK_SLOT) && l_q.ack_en;
            end
            bsp_pkg::PH_READ: begin
               if (l_q.bitcnt == 4'h0) begin
                  n_d.tx = r_q.rd_byte;
                  n_d.oe = ~r_q.rd_byte[7];
               end else if (l_q.bitcnt != `BSP_ACK_SLOT) begin
                  n_d.oe = ~n_q.tx[~l_q.bitcnt[2:0]];
               end
            end
            default: begin
               n_d.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(negedge scl_clk) begin
      n_q <= n_d;
   end

   // Core side: status flags, read pointer and command dispatch
   always_comb begin
      logic [3:0] code;
      logic [7:0] st;
      code = 4'h0;
      st = 8'h00;
      r_d = r_q;
      r_d.cmd_s1 = l_q.cmd_tgl;
      r_d.cmd_s2 = r_q.cmd_s1;
      r_d.cmd_prev = r_q.cmd_s2;
      r_d.rd_s1 = l_q.rd_tgl;
      r_d.rd_s2 = r_q.rd_s1;
      r_d.rd_prev = r_q.rd_s2;
      r_d.line_s1 = line_in;
      r_d.line_s2 = r_q.line_s1;
      r_d.sda_s1 = sda_in;
      r_d.sda_s2 = r_q.sda_s1;
      r_d.sda_prev = r_q.sda_s2;
      r_d.scl_s1 = scl_clk;
      r_d.scl_s2 = r_q.scl_s1;
      r_d.ow_start = 1'b0;
      r_d.ow_abort = 1'b0;
      r_d.cfg_wr = 1'b0;
      r_d.port_adj = 1'b0;

      // Start seen here because a clock that stops after a stop gives no edge
      if (!r_q.scl_s2) begin
         r_d.start_pend = 1'b0;
      end
      if (r_q.scl_s2 && r_q.sda_prev && !r_q.sda_s2) begin
         r_d.start_pend = 1'b1;
      end

      // A short at the presence sample also reads as presence
      if (r_q.op == bsp_pkg::OP_RESET && eng_presence_smp) begin
         r_d.status[`BSP_ST_PPD] = ~r_q.line_s2;
      end
      if (r_q.op == bsp_pkg::OP_RESET && eng_short_smp) begin
         r_d.status[`BSP_ST_SHORT] = ~r_q.line_s2;
      end
      if ((r_q.op == bsp_pkg::OP_BIT || r_q.op == bsp_pkg::OP_TRIP) && eng_bit1_smp) begin
         r_d.status[`BSP_ST_SBR] = r_q.line_s2;
      end
      if (r_q.op == bsp_pkg::OP_TRIP && eng_bit2_smp) begin
         r_d.status[`BSP_ST_TSB] = r_q.line_s2;
      end
      if (r_q.op == bsp_pkg::OP_TRIP && eng_dir_smp) begin
         r_d.status[`BSP_ST_DIR] = eng_dir;
      end
      if (eng_done) begin
         r_d.status[`BSP_ST_BUSY] = 1'b0;
         r_d.op = bsp_pkg::OP_NONE;
      end

      if (r_q.rd_s2 != r_q.rd_prev) begin
         if (l_q.rd_first && r_q.ptr == bsp_pkg::PTR_STATUS) begin
            r_d.status[`BSP_ST_LEVEL] = r_q.line_s2;
         end
         st = r_d.status;
         case (r_q.port_idx)
            3'h0: code = reset_low_std_code;
            3'h1: code = reset_low_od_code;
            3'h2: code = presence_std_code;
            3'h3: code = presence_od_code;
            3'h4: code = write_zero_std_code;
            3'h5: code = write_zero_od_code;
            3'h6: code = recovery_code;
            default: code = pullup_code;
         endcase
         case (r_q.ptr)
            bsp_pkg::PTR_STATUS: begin
               r_d.rd_byte = st;
            end
            bsp_pkg::PTR_CFG: begin
               r_d.rd_byte = {`BSP_HI_PAD, dev_cfg_code};
            end
            bsp_pkg::PTR_DATA: begin
               r_d.rd_byte = read_data;
            end
            default: begin
               r_d.rd_byte = {`BSP_HI_PAD, code};
               r_d.port_idx = r_q.port_idx + 3'h1;
            end
         endcase
      end

      if (r_q.cmd_s2 != r_q.cmd_prev) begin
         case (l_q.cmd)
            `BSP_CMD_DEV_RESET: begin
               r_d.status = `BSP_STATUS_RESET | (r_q.status & (8'h01 << `BSP_ST_LEVEL));
               r_d.op = bsp_pkg::OP_NONE;
               r_d.ow_abort = 1'b1;
               r_d.ptr = bsp_pkg::PTR_STATUS;
            end
            `BSP_CMD_SET_PTR: begin
               r_d.ptr = ptr_map(l_q.param);
               if (ptr_map(l_q.param) == bsp_pkg::PTR_PORT) begin
                  r_d.port_idx = 3'h0;
               end
            end
            `BSP_CMD_WR_CFG: begin
               r_d.cfg_wr = 1'b1;
               r_d.cfg_byte = l_q.param;
               // Only a well-formed configuration byte counts as executed
               if (l_q.param[7:4] == ~l_q.param[3:0]) begin
                  r_d.status[`BSP_ST_RST] = 1'b0;
               end
               r_d.ptr = bsp_pkg::PTR_CFG;
            end
            `BSP_CMD_ADJ_PORT: begin
               r_d.port_adj = 1'b1;
               r_d.port_param = l_q.param;
               r_d.ptr = bsp_pkg::PTR_PORT;
               r_d.port_idx = 3'h0;
            end
            default: begin
               case (l_q.cmd)
                  `BSP_CMD_OW_RESET: r_d.ow_op = bsp_pkg::OP_RESET;
                  `BSP_CMD_OW_BIT: r_d.ow_op = bsp_pkg::OP_BIT;
                  `BSP_CMD_OW_WBYTE: r_d.ow_op = bsp_pkg::OP_WBYTE;
                  `BSP_CMD_OW_RBYTE: r_d.ow_op = bsp_pkg::OP_RBYTE;
                  default: r_d.ow_op = bsp_pkg::OP_TRIP;
               endcase
               r_d.op = r_d.ow_op;
               r_d.ow_start = 1'b1;
               r_d.ow_param = l_q.param;
               // Set after the done handling so a new command wins a tie
               r_d.status[`BSP_ST_BUSY] = 1'b1;
               r_d.ptr = bsp_pkg::PTR_STATUS;
            end
         endcase
      end

      if (rst) begin
         r_d = '0;
         r_d.status = `BSP_STATUS_RESET;
         r_d.ptr = bsp_pkg::PTR_STATUS;
         r_d.op = bsp_pkg::OP_NONE;
         r_d.ow_op = bsp_pkg::OP_NONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      r_q <= r_d;
   end

   assign sda_oe = n_q.oe;
   assign ow_start = r_q.ow_start;
   assign ow_op = r_q.ow_op;
   assign ow_param = r_q.ow_param;
   assign ow_abort = r_q.ow_abort;
   assign cfg_wr = r_q.cfg_wr;
   assign cfg_byte = r_q.cfg_byte;
   assign port_adj = r_q.port_adj;
   assign port_param = r_q.port_param;
   assign status_byte = r_q.status;

endmodule
`default_nettype wire

/* testbench/bsp_host_model.sv */
// Host-side serial link master that issues function commands and reads registers
// Assumes the bench resolves the data wire from sda_low and the block's pull-down
`timescale 1ns/1ns
`default_nettype none
module bsp_host_model (
   output logic scl_clk,
   output logic sda_low,
   input wire logic sda_in
);
   // Each phase is 20 steps of 30 ns, since the block's crossings need 600 ns
   localparam int PH = 20;
   initial begin
      scl_clk = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half();
      repeat (PH) #30;
   endtask
   task automatic pulse_clk(input int n);
      repeat (n) begin
         half();
         scl_clk = 1'b0;
         half();
         scl_clk = 1'b1;
      end
   endtask
   // Data moves a little after the low edge so it never races the clock
   task automatic bit_x(input logic pull, output logic s);
      #60 sda_low = pull;
      half();
      scl_clk = 1'b1;
      s = sda_in;
      half();
      scl_clk = 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] tx, input logic pull9, output logic [7:0] rx,
                         output logic s9);
      for (int i = 7; i >= 0; i--) bit_x(!tx[i], rx[i]);
      bit_x(pull9, s9);
   endtask
   task automatic start();
      half();
      sda_low = 1'b1;
      half();
      scl_clk = 1'b0;
   endtask
   task automatic stop();
      #60 sda_low = 1'b1;
      half();
      scl_clk = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask
   task automatic cmd(input logic [6:0] a, input logic [7:0] c, p, input logic hp,
                      output logic [2:0] ack);
      logic [7:0] rx;
      logic s;
      ack = 3'h0;
      start();
      byte_x({a, 1'b0}, 1'b0, rx, s);
      ack[2] = !s;
      if (ack[2]) byte_x(c, 1'b0, rx, s);
      ack[1] = ack[2] && !s;
      if (hp && ack[1]) begin
         byte_x(p, 1'b0, rx, s);
         ack[0] = !s;
      end
      stop();
   endtask
   task automatic rd(input logic [6:0] a, input int n, output logic [79:0] d);
      logic [7:0] rx;
      logic s;
      d = 80'h0;
      start();
      byte_x({a, 1'b1}, 1'b0, rx, s);
      for (int i = 0; i < n; i++) begin
         byte_x(8'hff, i < n - 1, rx, s);
         d[8*i +: 8] = rx;
      end
      stop();
   endtask
endmodule
`default_nettype wire

/* testbench/bsp_status_port_monitor.sv */
// Assertions on the status byte and command strobes of the readback block
// Assumes it is bound to bsp_status_port; engine strobes come from the bench
`timescale 1ns/1ns
`default_nettype none
module bsp_status_port_mon (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic line_in,
   input wire logic eng_done,
   input wire logic eng_presence_smp,
   input wire logic eng_short_smp,
   input wire logic eng_bit1_smp,
   input wire logic eng_bit2_smp,
   input wire logic eng_dir_smp,
   input wire logic eng_dir,
   input wire logic ow_start,
   input var bsp_pkg::bsp_op_t ow_op,
   input wire logic ow_abort,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_byte,
   input wire logic [7:0] status_byte
);
   logic [1:0] age_q;
   logic line_q;
   logic steady;
   // Line checks only once the two-flop synchroniser has settled
   always_ff @(posedge ref_clk) begin
      line_q <= line_in;
      if (rst || line_in != line_q) begin
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   assign steady = line_in == line_q && age_q == 2'h3;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_reset_op;
      status_byte[0] && ow_op == bsp_pkg::OP_RESET;
   endsequence
   sequence s_trip_op;
      status_byte[0] && ow_op == bsp_pkg::OP_TRIP;
   endsequence
   chk_reset_value: assert property ($fell(rst) |-> status_byte == 8'h10)
      else $error("status wrong after reset");
   chk_start_busy: assert property (ow_start |-> ##[0:1] status_byte[0])
      else $error("busy not raised after start");
   chk_done_idle: assert property (eng_done && !ow_start ##1 !ow_start |-> !status_byte[0])
      else $error("busy not cleared after done");
   chk_start_pulse: assert property (ow_start |=> !ow_start)
      else $error("start longer than one cycle");
   chk_presence_smp: assert property (s_reset_op ##0 (eng_presence_smp && steady)
      |=> status_byte[1] == !$past(line_in))
      else $error("presence flag wrong");
   chk_short_smp: assert property (s_reset_op ##0 (eng_short_smp && steady)
      |=> status_byte[2] == !$past(line_in))
      else $error("short flag wrong");
   chk_bit_result: assert property (status_byte[0] && eng_bit1_smp && steady &&
      (ow_op == bsp_pkg::OP_BIT || ow_op == bsp_pkg::OP_TRIP) |=> status_byte[5] == $past(line_in))
      else $error("bit result wrong");
   chk_second_bit: assert property (s_trip_op ##0 (eng_bit2_smp && steady)
      |=> status_byte[6] == $past(line_in))
      else $error("second bit wrong");
   chk_branch_dir: assert property (s_trip_op ##0 eng_dir_smp |=> status_byte[7] == $past(eng_dir))
      else $error("direction wrong");
   chk_flags_hold: assert property (!status_byte[0] && !ow_abort ##1 !ow_abort
      |-> $stable(status_byte[7:5]) && $stable(status_byte[2:1]))
      else $error("flag changed while idle");
   chk_abort_clear: assert property (ow_abort |-> ##[0:1] (status_byte & 8'hf7) == 8'h10)
      else $error("device reset flags wrong");
   chk_cfg_clears: assert property (cfg_wr && cfg_byte[7:4] == ~cfg_byte[3:0]
      |-> ##[0:1] !status_byte[4])
      else $error("reset flag not cleared");
endmodule
`default_nettype wire

/* testbench/bsp_status_port_tb.sv */
// Self-checking bench for the status byte and port-timing readback block
// Assumes the host model, checker, package and defines are compiled with it
`timescale 1ns/1ns
`default_nettype none
`include "bsp_defines.svh"
module bsp_status_port_tb;
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] par;
      logic hp;
      logic ln;
      logic d;
      bsp_pkg::bsp_op_t op;
      logic [7:0] exp;
   } bsp_row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   wire logic scl_clk;
   wire logic sda_low;
   logic sda_oe;
   logic sda_in;
   logic line_in = 1'b1;
   logic eng_done = 1'b0;
   logic eng_dir = 1'b0;
   logic [4:0] smp = 5'h0;
   logic [3:0] codes [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
   logic ow_start, ow_abort, cfg_wr, port_adj;
   bsp_pkg::bsp_op_t ow_op;
   logic [7:0] ow_param, cfg_byte, port_param, status_byte;
   logic [3:0] seen = 4'h0;
   logic [2:0] ack;
   logic [79:0] rdat;
   int fail_count = 0;
   int checks = 0;
   bsp_row_t rows [8] = '{
      '{`BSP_CMD_OW_RESET, 8'h00, 1'b0, 1'b0, 1'b1, bsp_pkg::OP_RESET, 8'h16},
      '{`BSP_CMD_OW_RESET, 8'h00, 1'b0, 1'b1, 1'b0, bsp_pkg::OP_RESET, 8'h18},
      '{`BSP_CMD_OW_BIT, 8'h80, 1'b1, 1'b1, 1'b1, bsp_pkg::OP_BIT, 8'h38},
      '{`BSP_CMD_OW_TRIP, 8'h80, 1'b1, 1'b0, 1'b1, bsp_pkg::OP_TRIP, 8'h90},
      '{`BSP_CMD_OW_TRIP, 8'h00, 1'b1, 1'b1, 1'b0, bsp_pkg::OP_TRIP, 8'h78},
      '{`BSP_CMD_OW_RESET, 8'h00, 1'b0, 1'b0, 1'b1, bsp_pkg::OP_RESET, 8'h76},
      '{`BSP_CMD_OW_WBYTE, 8'h5a, 1'b1, 1'b1, 1'b1, bsp_pkg::OP_WBYTE, 8'h7e},
      '{`BSP_CMD_OW_RBYTE, 8'h00, 1'b0, 1'b0, 1'b1, bsp_pkg::OP_RBYTE, 8'h76}};
   always #20 ref_clk = ~ref_clk;
   assign sda_in = !(sda_oe || sda_low);
   always @(posedge ref_clk) seen <= seen | {ow_start, ow_abort, cfg_wr, port_adj};
   bsp_host_model u_host (.scl_clk(scl_clk), .sda_low(sda_low), .sda_in(sda_in));
   bsp_status_port u_dut (.ref_clk(ref_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in),
      .sda_oe(sda_oe), .line_in(line_in), .eng_done(eng_done), .eng_presence_smp(smp[4]),
      .eng_short_smp(smp[3]), .eng_bit1_smp(smp[2]), .eng_bit2_smp(smp[1]),
      .eng_dir_smp(smp[0]), .eng_dir(eng_dir), .read_data(8'h3c), .dev_cfg_code(4'h9),
      .reset_low_std_code(codes[0]), .reset_low_od_code(codes[1]),
      .presence_std_code(codes[2]), .presence_od_code(codes[3]),
      .write_zero_std_code(codes[4]), .write_zero_od_code(codes[5]),
      .recovery_code(codes[6]), .pullup_code(codes[7]), .ow_start(ow_start), .ow_op(ow_op),
      .ow_param(ow_param), .ow_abort(ow_abort), .cfg_wr(cfg_wr), .cfg_byte(cfg_byte),
      .port_adj(port_adj), .port_param(port_param), .status_byte(status_byte));
   task automatic chk(input logic [7:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // The link side resynchronises reset, so the link clock runs while it is held
   task automatic do_reset();
      @(negedge ref_clk) rst = 1'b1;
      u_host.pulse_clk(3);
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      u_host.pulse_clk(3);
   endtask
   task automatic send(input logic [7:0] c, p, input logic hp);
      @(negedge ref_clk) seen = 4'h0;
      u_host.cmd(`BSP_LINK_ADDR, c, p, hp, ack);
      @(negedge ref_clk);
   endtask
   task automatic rd1();
      u_host.rd(`BSP_LINK_ADDR, 1, rdat);
      @(negedge ref_clk);
   endtask
   // Fires every sample strobe in turn, so strobes of foreign commands are exercised too
   task automatic engine(input logic d);
      @(negedge ref_clk) eng_dir = d;
      for (int k = 0; k < 6; k++) begin
         @(negedge ref_clk) smp = 5'h10 >> k;
      end
      @(negedge ref_clk) eng_done = 1'b1;
      @(negedge ref_clk) eng_done = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   initial begin
      do_reset();
      chk(status_byte, `BSP_STATUS_RESET, "reset status");
      foreach (rows[i]) begin
         @(negedge ref_clk) line_in = rows[i].ln;
         send(rows[i].code, rows[i].par, rows[i].hp);
         chk({5'h0, ack}, rows[i].hp ? 8'h07 : 8'h06, "cmd ack");
         chk({7'h0, seen[3]}, 8'h01, "start");
         chk({5'h0, ow_op}, {5'h0, rows[i].op}, "op");
         if (rows[i].hp) chk(ow_param, rows[i].par, "param");
         chk({7'h0, status_byte[0]}, 8'h01, "busy");
         engine(rows[i].d);
         chk({7'h0, status_byte[0]}, 8'h00, "idle");
         rd1();
         chk(rdat[7:0], rows[i].exp, "status read");
         chk(status_byte, rows[i].exp, "status");
      end
      send(`BSP_CMD_ADJ_PORT, 8'h3b, 1'b1);
      chk({7'h0, seen[0]}, 8'h01, "adjust");
      chk(port_param, 8'h3b, "adjust param");
      u_host.rd(`BSP_LINK_ADDR, 10, rdat);
      for (int i = 0; i < 10; i++) chk(rdat[8*i +: 8], {4'h0, codes[i % 8]}, "port");
      send(`BSP_CMD_SET_PTR, `BSP_PTR_PORT, 1'b1);
      rd1();
      chk(rdat[7:0], {4'h0, codes[0]}, "port restart");
      send(`BSP_CMD_SET_PTR, 8'h55, 1'b1);
      chk({5'h0, ack}, 8'h06, "bad pointer");
      rd1();
      chk(rdat[7:0], {4'h0, codes[1]}, "pointer kept");
      send(`BSP_CMD_SET_PTR, `BSP_PTR_DATA, 1'b1);
      rd1();
      chk(rdat[7:0], 8'h3c, "read data");
      u_host.cmd(`BSP_LINK_ADDR + 7'h1, `BSP_CMD_DEV_RESET, 8'h00, 1'b0, ack);
      chk({5'h0, ack}, 8'h00, "wrong address");
      send(8'h11, 8'h00, 1'b0);
      chk({5'h0, ack}, 8'h04, "unknown code");
      send(`BSP_CMD_OW_RESET, 8'h00, 1'b0);
      send(`BSP_CMD_WR_CFG, 8'he1, 1'b1);
      chk({4'h0, ack, seen[1]}, 8'h08, "config while busy");
      engine(1'b0);
      send(`BSP_CMD_WR_CFG, 8'he1, 1'b1);
      chk({4'h0, ack, seen[1]}, 8'h0f, "config");
      chk(cfg_byte, 8'he1, "config byte");
      chk(status_byte, 8'h66, "config status");
      rd1();
      chk(rdat[7:0], 8'h09, "config pointer");
      send(`BSP_CMD_DEV_RESET, 8'h00, 1'b0);
      chk({4'h0, ack, seen[2]}, 8'h0d, "device reset");
      chk(status_byte, 8'h10, "reset flags");
      rd1();
      chk(rdat[7:0], 8'h10, "status after reset");
      send(`BSP_CMD_OW_RESET, 8'h00, 1'b0);
      engine(1'b1);
      do_reset();
      chk(status_byte, 8'h10, "second reset");
      rd1();
      chk(rdat[7:0], 8'h10, "status pointer");
      engine(1'b1);
      chk(status_byte, 8'h10, "idle strobes");
      end_of_test();
   end
endmodule
bind bsp_status_port bsp_status_port_mon u_mon (.ref_clk(ref_clk), .rst(rst),
   .line_in(line_in), .eng_done(eng_done), .eng_presence_smp(eng_presence_smp),
   .eng_short_smp(eng_short_smp), .eng_bit1_smp(eng_bit1_smp), .eng_bit2_smp(eng_bit2_smp),
   .eng_dir_smp(eng_dir_smp), .eng_dir(eng_dir), .ow_start(ow_start), .ow_op(ow_op),
   .ow_abort(ow_abort), .cfg_wr(cfg_wr), .cfg_byte(cfg_byte), .status_byte(status_byte));
`default_nettype wire
